// [core/fobl_consts.vh]
// constants of the flash option byte loader: option area layout, register
// indices, reset values, write keys and field codes.
// assumes a byte-wide flash read port and an apb register bus.
`ifndef FOBL_CONSTS_VH
`define FOBL_CONSTS_VH

// option area
`define FOBL_OPT_BASE_16K    14'h3FF8
`define FOBL_OPT_BASE_8K     14'h1FF8
`define FOBL_OPT_COUNT       4'h8
`define FOBL_IDX_ENABLE      3'h0
`define FOBL_IDX_PROTECT     3'h4
`define FOBL_IDX_PIN         3'h5
`define FOBL_IDX_OSC         3'h6
`define FOBL_IDX_PWR         3'h7
`define FOBL_ENABLE_CODE     8'hAF
`define FOBL_PROT_NO_WRITE   8'h00
`define FOBL_PROT_NO_READ    8'h10
`define FOBL_PROT_NONE       8'hFF

// register indices, byte address is four times the index
`define FOBL_REG_LVD_CTL     6'h02
`define FOBL_REG_CLK_SRC     6'h05
`define FOBL_REG_CLK_PD      6'h07
`define FOBL_REG_OSC_DRV     6'h08
`define FOBL_REG_CCODE1      6'h0D
`define FOBL_REG_CCODE2      6'h0E
`define FOBL_REG_CCODE3      6'h0F
`define FOBL_REG_PA_FUN1     6'h25
`define FOBL_REG_PA_FUN2     6'h26
`define FOBL_REG_LOAD_STAT   6'h30

// reset values
`define FOBL_RST_LVD_CTL     8'hA6
`define FOBL_RST_CLK_SRC     8'hA0
`define FOBL_RST_CLK_PD      8'hA2
`define FOBL_RST_OSC_DRV     8'h54
`define FOBL_RST_CCODE       8'hFF
`define FOBL_RST_PA_FUN      8'h00

// write keys in the upper bits of the clock registers
`define FOBL_KEY_CLK_SRC     4'hA
`define FOBL_KEY_OSC_DRV     4'h5
`define FOBL_KEY_CLK_PD      3'h5

// field codes written by the loader
`define FOBL_FUN_EXTERNAL_RESET_INPUT        3'h2
`define FOBL_FUN_XTAL        3'h2
`define FOBL_FUN_GPIO        3'h0

`endif

// [core/fobl_loader.v]
// flash option byte loader with its apb register file.
// assumes a flash read port that answers each one-cycle read strobe with
// flash_rvalid some cycles later, and a cpu that waits while cpu_hold is high.
`timescale 1ns/1ps
`include "fobl_consts.vh"

module fobl_loader #(
  parameter SMALL_PART = 0
) (
  // apb
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // flash read port
  output reg  [13:0] flash_addr,
  output reg         flash_rd,
  input  wire [7:0]  flash_rdata,
  input  wire        flash_rvalid,
  // flash protection
  output reg         flash_write_block,
  output reg         flash_read_block,
  // cpu start control
  output reg         cpu_hold,
  // mapped register contents
  output reg  [7:0]  lvd_ctl_reg,
  output reg  [7:0]  clk_src_reg,
  output reg  [7:0]  clk_pd_reg,
  output reg  [7:0]  osc_drv_reg,
  output reg  [7:0]  port_a_pin_function_select_1,
  output reg  [7:0]  port_a_pin_function_select_2
);

  ////////////////////////////////////////////////////////////////////////////
  // loader states

  localparam [3:0] ST_ISSUE = 4'h1;
  localparam [3:0] ST_WAIT  = 4'h2;
  localparam [3:0] ST_APPLY = 4'h4;
  localparam [3:0] ST_DONE  = 4'h8;

  reg [3:0]  state_reg;
  reg [3:0]  state_next;
  reg [2:0]  idx_reg;
  reg [7:0]  byte_reg;
  reg        load_en_reg;
  reg [7:0]  prot_reg;
  reg [7:0]  customer_code_byte_1;
  reg [7:0]  customer_code_byte_2;
  reg [7:0]  customer_code_byte_3;

  wire [13:0] opt_base;
  wire [5:0]  reg_idx;
  wire        apb_access;
  wire        wr_go;
  wire        last_byte;

  assign opt_base  = (SMALL_PART != 0) ? `FOBL_OPT_BASE_8K : `FOBL_OPT_BASE_16K;
  assign reg_idx   = paddr[7:2];
  // register access is held off until the load finishes, so the loader and
  // software never update the same register in one cycle
  assign apb_access = psel & penable & ~pready & state_reg[3];
  assign wr_go      = apb_access & pwrite;
  assign last_byte  = (idx_reg == (`FOBL_OPT_COUNT - 4'h1));

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_ISSUE: begin
        state_next = ST_WAIT;
      end
      ST_WAIT: begin
        if (flash_rvalid) begin
          state_next = ST_APPLY;
        end
      end
      ST_APPLY: begin
        if (last_byte) begin
          state_next = ST_DONE;
        end else begin
          state_next = ST_ISSUE;
        end
      end
      ST_DONE: begin
        state_next = ST_DONE;
      end
      default: begin
        state_next = ST_ISSUE;
      end
    endcase
  end

  // any reset restarts the whole load
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_ISSUE;
      idx_reg   <= 3'h0;
      byte_reg  <= 8'hFF;
    end else begin
      state_reg <= state_next;
      if (state_reg[1] && flash_rvalid) begin
        byte_reg <= flash_rdata;
      end
      if (state_reg[2] && !last_byte) begin
        idx_reg <= idx_reg + 3'h1;
      end
    end
  end

  // one strobe per option byte
  // address is set with the strobe and stands until the next one
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_addr <= 14'h0000;
      flash_rd   <= 1'b0;
    end else begin
      flash_rd <= state_reg[0];
      if (state_reg[0]) begin
        flash_addr <= opt_base + {11'h000, idx_reg};
      end
    end
  end

  // cpu waits for the last byte
  // hold is taken from the next state so it drops on the same edge that
  // opens the bus, never a cycle after it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_hold <= 1'b1;
    end else begin
      cpu_hold <= ~state_next[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // loader switch and protection

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_en_reg <= 1'b0;
      prot_reg    <= `FOBL_PROT_NONE;
    end else begin
      if (state_reg[2] && idx_reg == `FOBL_IDX_ENABLE) begin
        load_en_reg <= (byte_reg == `FOBL_ENABLE_CODE);
      end
      if (state_reg[2] && idx_reg == `FOBL_IDX_PROTECT) begin
        prot_reg <= byte_reg;
      end
    end
  end

  // any value other than the two codes leaves the flash open
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_write_block <= 1'b0;
      flash_read_block  <= 1'b0;
    end else begin
      flash_write_block <= (prot_reg == `FOBL_PROT_NO_WRITE);
      flash_read_block  <= (prot_reg == `FOBL_PROT_NO_READ);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // customer code

  // no bus write path, so the code stays read-only
  // a disabled load keeps the reset value in all three bytes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      customer_code_byte_1 <= `FOBL_RST_CCODE;
      customer_code_byte_2 <= `FOBL_RST_CCODE;
      customer_code_byte_3 <= `FOBL_RST_CCODE;
    end else begin
      if (state_reg[2] && load_en_reg) begin
        if (idx_reg == 3'h1) begin
          customer_code_byte_1 <= byte_reg;
        end
        if (idx_reg == 3'h2) begin
          customer_code_byte_2 <= byte_reg;
        end
        if (idx_reg == 3'h3) begin
          customer_code_byte_3 <= byte_reg;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mapped registers

  // loads land only while the bus is held off, so they never meet a write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvd_ctl_reg                  <= `FOBL_RST_LVD_CTL;
      clk_src_reg                  <= `FOBL_RST_CLK_SRC;
      clk_pd_reg                   <= `FOBL_RST_CLK_PD;
      osc_drv_reg                  <= `FOBL_RST_OSC_DRV;
      port_a_pin_function_select_1 <= `FOBL_RST_PA_FUN;
      port_a_pin_function_select_2 <= `FOBL_RST_PA_FUN;
    end else begin
      if (state_reg[2]) begin
        if (load_en_reg) begin
          case (idx_reg)
            `FOBL_IDX_PIN: begin
              port_a_pin_function_select_2[6:4] <=
                byte_reg[4] ? `FOBL_FUN_EXTERNAL_RESET_INPUT : `FOBL_FUN_GPIO;
              port_a_pin_function_select_1[2:0] <=
                byte_reg[3] ? `FOBL_FUN_XTAL : `FOBL_FUN_GPIO;
              lvd_ctl_reg[2] <= byte_reg[2];
              lvd_ctl_reg[1:0] <= byte_reg[1:0];
            end
            `FOBL_IDX_OSC: begin
              clk_src_reg[3:2] <= byte_reg[4:3];
              osc_drv_reg[2:1] <= byte_reg[2:1];
              osc_drv_reg[0] <= byte_reg[0];
            end
            `FOBL_IDX_PWR: begin
              clk_pd_reg[4] <= byte_reg[4];
              clk_pd_reg[3] <= byte_reg[3];
              clk_pd_reg[1] <= byte_reg[1];
            end
            default: begin
            end
          endcase
        end
      end
      if (wr_go) begin
        if (reg_idx == `FOBL_REG_LVD_CTL) begin
          // comparator result bit 6 is read-only
          lvd_ctl_reg <= {pwdata[7], lvd_ctl_reg[6], pwdata[5:0]};
        end else if (reg_idx == `FOBL_REG_CLK_SRC) begin
          // upper key must match, else the low bits stay put
          if (pwdata[7:4] == `FOBL_KEY_CLK_SRC) begin
            clk_src_reg[3:0] <= pwdata[3:0];
          end
        end else if (reg_idx == `FOBL_REG_CLK_PD) begin
          if (pwdata[7:5] == `FOBL_KEY_CLK_PD) begin
            clk_pd_reg[4:1] <= pwdata[4:1];
          end
        end else if (reg_idx == `FOBL_REG_OSC_DRV) begin
          if (pwdata[7:4] == `FOBL_KEY_OSC_DRV) begin
            osc_drv_reg[2:0] <= pwdata[2:0];
          end
        end else if (reg_idx == `FOBL_REG_PA_FUN1) begin
          port_a_pin_function_select_1 <= {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
        end else if (reg_idx == `FOBL_REG_PA_FUN2) begin
          port_a_pin_function_select_2 <= {1'b0, pwdata[6:4], 1'b0, pwdata[2:0]};
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer

  // one compare per register, shared by the read mux below
  wire       sel_ccode1;
  wire       sel_ccode2;
  wire       sel_ccode3;
  wire       sel_lvd;
  wire       sel_src;
  wire       sel_pd;
  wire       sel_drv;
  wire       sel_fun1;
  wire       sel_fun2;
  wire       sel_stat;
  wire       sel_prot;
  wire       addr_bad;

  reg [7:0] rd_byte;
  reg       rd_hit;

  assign sel_ccode1 = (reg_idx == `FOBL_REG_CCODE1);
  assign sel_ccode2 = (reg_idx == `FOBL_REG_CCODE2);
  assign sel_ccode3 = (reg_idx == `FOBL_REG_CCODE3);
  assign sel_lvd    = (reg_idx == `FOBL_REG_LVD_CTL);
  assign sel_src    = (reg_idx == `FOBL_REG_CLK_SRC);
  assign sel_pd     = (reg_idx == `FOBL_REG_CLK_PD);
  assign sel_drv    = (reg_idx == `FOBL_REG_OSC_DRV);
  assign sel_fun1   = (reg_idx == `FOBL_REG_PA_FUN1);
  assign sel_fun2   = (reg_idx == `FOBL_REG_PA_FUN2);
  assign sel_stat   = (reg_idx == `FOBL_REG_LOAD_STAT);
  assign sel_prot   = (reg_idx == (`FOBL_REG_LOAD_STAT + 6'h01));
  // low bits and the upper nibble must be clear, else the access errors
  assign addr_bad   = (paddr[1:0] != 2'h0) || (paddr[11:8] != 4'h0);

  always @* begin
    rd_byte = 8'h00;
    rd_hit  = 1'b1;
    if (sel_ccode1) begin
      rd_byte = customer_code_byte_1;
    end else if (sel_ccode2) begin
      rd_byte = customer_code_byte_2;
    end else if (sel_ccode3) begin
      rd_byte = customer_code_byte_3;
    end else if (sel_lvd) begin
      rd_byte = lvd_ctl_reg;
    end else if (sel_src) begin
      rd_byte = clk_src_reg;
    end else if (sel_pd) begin
      rd_byte = clk_pd_reg;
    end else if (sel_drv) begin
      rd_byte = osc_drv_reg;
    end else if (sel_fun1) begin
      rd_byte = port_a_pin_function_select_1;
    end else if (sel_fun2) begin
      rd_byte = port_a_pin_function_select_2;
    end else if (sel_stat) begin
      rd_byte = {6'h00, load_en_reg, state_reg[3]};
    end else if (sel_prot) begin
      rd_byte = prot_reg;
    end else begin
      rd_hit = 1'b0;
    end
    if (addr_bad) begin
      rd_hit = 1'b0;
    end
  end

  // one wait state once the load is done: pready rises the cycle after penable, or the cycle after the load ends
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_access;
      pslverr <= apb_access & ~rd_hit;
    end
  end

  // read data is only loaded by a read, so it keeps the last answer while
  // writes and idle cycles pass
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      if (apb_access && !pwrite) begin
        prdata <= {24'h000000, rd_hit ? rd_byte : 8'h00};
      end
    end
  end

endmodule

// [verif/fobl_check_sva.sv]
// port checker for the option loader.
// assumes one clock; bound to the loader at the foot of this file.
`timescale 1ns/1ps
`include "fobl_consts.vh"
module fobl_check #(
  parameter SMALL_PART = 0
) (
  // watched ports
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire [11:0] paddr,
  input wire        pready,
  input wire        pslverr,
  input wire [13:0] flash_addr,
  input wire        flash_rd,
  input wire        flash_rvalid,
  input wire        flash_write_block,
  input wire        cpu_hold
);
  wire [13:0] base = SMALL_PART ? `FOBL_OPT_BASE_8K : `FOBL_OPT_BASE_16K;
  reg  [3:0]  n_rd;
  reg  [13:0] last;
  ////////////////////////////////////////////////////////////////////
  // strobes counted from reset, so a second reset restarts the order
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_rd <= 4'h0;
      last <= 14'h0;
    end else if (flash_rd) begin
      n_rd <= n_rd + 4'h1;
      last <= flash_addr;
    end
  end
  ////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_first; flash_rd && flash_addr == base; endsequence
  sequence s_issue; ##[1:4] flash_rd; endsequence
  property p_first; $rose(presetn) |-> ##[1:3] s_first; endproperty
  a_first: assert property (p_first) else $error("load not started");
  property p_range; flash_rd |-> flash_addr[13:3] == base[13:3]; endproperty
  a_range: assert property (p_range) else $error("read outside option area");
  property p_order; flash_rd && n_rd != 4'h0 |-> flash_addr == last + 14'h1; endproperty
  a_order: assert property (p_order) else $error("option bytes out of order");
  property p_pace; flash_rvalid && n_rd != 4'h8 |-> s_issue; endproperty
  a_pace: assert property (p_pace) else $error("next byte not fetched");
  property p_done; $fell(cpu_hold) |-> n_rd == 4'h8; endproperty
  a_done: assert property (p_done) else $error("cpu released early");
  property p_stall; cpu_hold |-> !pready; endproperty
  a_stall: assert property (p_stall) else $error("bus answered during load");
  property p_answer; psel && penable && !pready && !cpu_hold |=> pready; endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");
  property p_err; pready && paddr[11:8] != 4'h0 |-> pslverr; endproperty
  a_err: assert property (p_err) else $error("unmapped access not flagged");
  property p_prot; !cpu_hold && !$past(cpu_hold) |-> $stable(flash_write_block); endproperty
  a_prot: assert property (p_prot) else $error("protection moved after load");
endmodule

bind fobl_loader fobl_check #(.SMALL_PART(SMALL_PART)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr), .flash_rd(flash_rd),
  .flash_rvalid(flash_rvalid), .flash_write_block(flash_write_block), .cpu_hold(cpu_hold)
);

// [verif/fobl_flash.sv]
// option area of the program flash, seen through the loader read port.
// assumes one strobe at a time; delay and image come from the bench.
`timescale 1ns/1ps
module fobl_flash (
  // loader side
  input  wire        pclk,
  input  wire        presetn,
  input  wire [13:0] flash_addr,
  input  wire        flash_rd,
  output reg  [7:0]  flash_rdata,
  output reg         flash_rvalid,
  // image and answer delay
  input  wire [63:0] img,
  input  wire [3:0]  lat
);
  reg [3:0] cnt;
  reg [7:0] pend;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      pend <= 8'h00;
      flash_rvalid <= 1'b0;
      flash_rdata <= 8'h5A;
    end else if (flash_rd) begin
      cnt <= lat;
      pend <= img[{flash_addr[2:0], 3'h0} +: 8];
      flash_rvalid <= 1'b0;
      flash_rdata <= ~flash_rdata;
    end else begin
      cnt <= (cnt != 4'h0) ? cnt - 4'h1 : 4'h0;
      flash_rvalid <= (cnt == 4'h1);
      // data toggles when idle so a stale byte is never mistaken
      flash_rdata <= (cnt == 4'h1) ? pend : ~flash_rdata;
    end
  end
endmodule

// [verif/fobl_loader_bench.sv]
// self-checking bench for the option loader.
// assumes the flash model and the bound checker beside it.
`timescale 1ns/1ps
`include "fobl_consts.vh"
module fobl_loader_bench;
  reg         pclk = 1'b0;
  reg         presetn = 1'b0;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg  [63:0] img = {64{1'b1}};
  reg  [3:0]  lat = 4'h1;
  reg  [63:0] t;
  reg  [33:0] e;
  reg  [33:0] q[$];
  reg         en;
  wire [31:0] prdata;
  wire [13:0] flash_addr;
  wire [7:0]  flash_rdata;
  wire        pready, pslverr, flash_rd, flash_rvalid, wblk, rblk, cpu_hold;
  wire [7:0]  lvd, csrc, cpd, odrv, pf1, pf2;
  integer     fails = 0;
  integer     compares = 0;
  integer     cyc = 0;
  integer     i;
  always #4 pclk = ~pclk;
  fobl_loader #(.SMALL_PART(0)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flash_addr(flash_addr), .flash_rd(flash_rd),
    .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid), .flash_write_block(wblk),
    .flash_read_block(rblk), .cpu_hold(cpu_hold), .lvd_ctl_reg(lvd), .clk_src_reg(csrc),
    .clk_pd_reg(cpd), .osc_drv_reg(odrv), .port_a_pin_function_select_1(pf1),
    .port_a_pin_function_select_2(pf2));
  fobl_flash u_fl (.pclk(pclk), .presetn(presetn), .flash_addr(flash_addr),
    .flash_rd(flash_rd), .flash_rdata(flash_rdata), .flash_rvalid(flash_rvalid),
    .img(img), .lat(lat));
  ////////////////////////////////////////////////////////////////////
  task finish_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      finish_test;
    end
  end
  // oldest note is matched against each bus answer
  always @(posedge pclk) begin
    if (pready === 1'b1) begin
      e = q.pop_front();
      chk("pslverr", {31'h0, e[32]}, {31'h0, pslverr});
      if (e[33]) chk("prdata", e[31:0], prdata);
    end
  end
  ////////////////////////////////////////////////////////////////////
  task apb(input w, input [11:0] a, input [31:0] d, input [33:0] ex);
    q.push_back(ex);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input [5:0] idx, input [7:0] d);
    apb(1'b0, {4'h0, idx, 2'h0}, 32'h0, {2'h2, 24'h0, d});
  endtask
  task wr(input [5:0] idx, input [7:0] d);
    apb(1'b1, {4'h0, idx, 2'h0}, {24'h0, d}, 34'h0);
  endtask
  // read issued at release stalls until the load is applied
  task boot;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`FOBL_REG_CCODE1, en ? t[15:8] : `FOBL_RST_CCODE);
    chk("cpu_hold", 0, cpu_hold);
  endtask
  task verify;
    rd(`FOBL_REG_CCODE2, en ? t[23:16] : `FOBL_RST_CCODE);
    rd(`FOBL_REG_CCODE3, en ? t[31:24] : `FOBL_RST_CCODE);
    rd(`FOBL_REG_LVD_CTL, en ? {5'h14, t[42:40]} : `FOBL_RST_LVD_CTL);
    rd(`FOBL_REG_CLK_SRC, en ? {4'hA, t[52:51], 2'h0} : `FOBL_RST_CLK_SRC);
    rd(`FOBL_REG_OSC_DRV, en ? {5'h0A, t[50:48]} : `FOBL_RST_OSC_DRV);
    rd(`FOBL_REG_CLK_PD, en ? {3'h5, t[60:59], 1'b0, t[57], 1'b0} : `FOBL_RST_CLK_PD);
    rd(`FOBL_REG_PA_FUN1, en ? {6'h0, t[43], 1'b0} : `FOBL_RST_PA_FUN);
    rd(`FOBL_REG_PA_FUN2, en ? {2'h0, t[44], 5'h0} : `FOBL_RST_PA_FUN);
    chk("write_block", {31'h0, t[39:32] == 8'h00}, {31'h0, wblk});
    chk("read_block", {31'h0, t[39:32] == 8'h10}, {31'h0, rblk});
    chk("lvd_port", en ? {5'h14, t[42:40]} : `FOBL_RST_LVD_CTL, {24'h0, lvd});
    chk("src_port", en ? {4'hA, t[52:51], 2'h0} : `FOBL_RST_CLK_SRC, {24'h0, csrc});
    chk("drv_port", en ? {5'h0A, t[50:48]} : `FOBL_RST_OSC_DRV, {24'h0, odrv});
    chk("pd_port", en ? {3'h5, t[60:59], 1'b0, t[57], 1'b0} : `FOBL_RST_CLK_PD, {24'h0, cpd});
    chk("fun1_port", en ? {6'h0, t[43], 1'b0} : `FOBL_RST_PA_FUN, {24'h0, pf1});
    chk("fun2_port", en ? {2'h0, t[44], 5'h0} : `FOBL_RST_PA_FUN, {24'h0, pf2});
  endtask
  ////////////////////////////////////////////////////////////////////
  initial begin
    i = $urandom(24);
    for (i = 0; i < 6; i = i + 1) begin
      @(posedge pclk);
      t = {$urandom, $urandom};
      t[7:0] = (i == 4) ? 8'hAE : `FOBL_ENABLE_CODE;
      case (i)
        1: t[39:32] = `FOBL_PROT_NO_WRITE;
        2, 4: t[39:32] = `FOBL_PROT_NO_READ;
        3: t[39:32] = `FOBL_PROT_NONE;
        default: ;
      endcase
      if (i == 0) t = {64{1'b1}};
      en = (t[7:0] == `FOBL_ENABLE_CODE);
      img <= t;
      lat <= 4'($urandom % 3) + 4'h1;
      boot;
      verify;
      if (i == 1) begin
        wr(`FOBL_REG_CLK_SRC, 8'hA5);
        wr(`FOBL_REG_CLK_SRC, 8'h39);
        rd(`FOBL_REG_CLK_SRC, 8'hA5);
        wr(`FOBL_REG_CCODE1, 8'h00);
        rd(`FOBL_REG_CCODE1, t[15:8]);
        wr(`FOBL_REG_PA_FUN1, 8'h45);
        rd(`FOBL_REG_PA_FUN1, 8'h45);
        apb(1'b0, 12'h800, 32'h0, {2'h1, 32'h0});
      end
      $display("test %0d done", i);
    end
    finish_test;
  end
endmodule
